// ==== src/cma_csr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cma_csr_cfg.svh"
module cma_csr_bank #(
  parameter int          clic_mode_param     = 0,
  parameter int          trigger_count_param = 1,
  // Identity values are arbitrary.
  parameter logic [31:0] vendor_id           = 32'h0000_0000,
  parameter logic [31:0] arch_id             = 32'h0000_0000,
  parameter logic [31:0] impl_id             = 32'h0000_0000,
  parameter logic [31:0] hart_id             = 32'h0000_0000,
  parameter logic [31:0] cfg_ptr             = 32'h0000_0000
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Instruction request.
  input  wire logic        csr_req,
  input  wire logic [11:0] csr_addr,
  input  wire logic        csr_wr,
  input  wire logic [31:0] csr_wdata,
  // Current hart state.
  input  wire logic [1:0]  priv_lvl,
  input  wire logic        debug_mode,
  input  wire logic        instr_retire,
  // Answer.
  output logic             csr_done_q,
  output logic             csr_illegal_q,
  output logic [31:0]      csr_rdata_q
);

  localparam int NR = `CMA_NREG;

  if (clic_mode_param < 0 || clic_mode_param > 1 || trigger_count_param < 0) begin : g_chk
    $error("cma_csr_bank: unsupported parameter value");
  end

  localparam logic clic_on = (clic_mode_param == 1);
  localparam logic trig_on = (trigger_count_param > 0);

  logic [31:0] regs_q [NR];
  logic [63:0] cyc_q;
  logic [63:0] ret_q;

  // Address decode: access class, storage index and read source.
  logic             dec_hit;
  cma_pkg::cma_acc_t dec_acc;
  logic [5:0]       dec_idx;
  cma_pkg::cma_src_t dec_src;
  logic [31:0]      dec_const;

  always_comb begin
    dec_hit   = 1'b1;
    dec_acc   = cma_pkg::CMA_ACC_MRW;
    dec_idx   = 6'h00;
    dec_src   = cma_pkg::CMA_SRC_REG;
    dec_const = `CMA_RST_VAL;
    case (csr_addr)
      `CMA_A_STATUS:    dec_idx = 6'h00;
      `CMA_A_ISA:       dec_idx = 6'h01;
      `CMA_A_IE:        dec_idx = 6'h02;
      `CMA_A_TVEC:      dec_idx = 6'h03;
      `CMA_A_TVT: begin
        dec_idx = 6'h04;
        dec_hit = clic_on;
      end
      `CMA_A_STATUSH:   dec_idx = 6'h05;
      `CMA_A_CNTINH:    dec_idx = 6'h06;
      `CMA_A_HPMEV3:    dec_idx = 6'h07;
      `CMA_A_HPMEV31:   dec_idx = 6'h08;
      `CMA_A_MSCRATCH:  dec_idx = 6'h09;
      `CMA_A_TRAP_PC:   dec_idx = 6'h0A;
      `CMA_A_CAUSE:     dec_idx = 6'h0B;
      `CMA_A_TVAL:      dec_idx = 6'h0C;
      `CMA_A_IRQ_PEND:  dec_idx = 6'h0D;
      `CMA_A_NXT_IRQ: begin
        dec_idx = 6'h0E;
        dec_hit = clic_on;
      end
      `CMA_A_THRESH: begin
        dec_idx = 6'h0F;
        dec_hit = clic_on;
      end
      `CMA_A_SWAP_PRIV: begin
        dec_idx = 6'h10;
        dec_hit = clic_on;
      end
      `CMA_A_SWAP_LVL: begin
        dec_idx = 6'h11;
        dec_hit = clic_on;
      end
      `CMA_A_TSEL, `CMA_A_TRIGGER_DATA_1, `CMA_A_TRIGGER_DATA_2,
      `CMA_A_TRIGGER_DATA_3, `CMA_A_TINFO, `CMA_A_TCTRL: begin
        dec_idx = 6'h12 + {3'h0, csr_addr[2:0]};
        dec_hit = trig_on;
      end
      `CMA_A_DBG_CS: begin
        dec_idx = 6'h18;
        dec_acc = cma_pkg::CMA_ACC_DRW;
      end
      `CMA_A_DSCR0: begin
        dec_idx = 6'h19;
        dec_acc = cma_pkg::CMA_ACC_DRW;
      end
      `CMA_A_DSCR1: begin
        dec_idx = 6'h1A;
        dec_acc = cma_pkg::CMA_ACC_DRW;
      end
      `CMA_A_CYC_LO, `CMA_A_CYC_HI: dec_src = cma_pkg::CMA_SRC_CYC;
      `CMA_A_RET_LO, `CMA_A_RET_HI: dec_src = cma_pkg::CMA_SRC_RET;
      `CMA_A_HPMC3:     dec_idx = 6'h1B;
      `CMA_A_HPMC31:    dec_idx = 6'h1C;
      `CMA_A_HPMCH3:    dec_idx = 6'h1D;
      `CMA_A_HPMCH31:   dec_idx = 6'h1E;
      `CMA_A_VENDOR, `CMA_A_ARCH, `CMA_A_IMPL,
      `CMA_A_HART, `CMA_A_CFGPTR: begin
        dec_acc = cma_pkg::CMA_ACC_MRO;
        dec_src = cma_pkg::CMA_SRC_CONST;
        case (csr_addr[2:0])
          3'h1:    dec_const = vendor_id;
          3'h2:    dec_const = arch_id;
          3'h3:    dec_const = impl_id;
          3'h4:    dec_const = hart_id;
          default: dec_const = cfg_ptr;
        endcase
      end
      `CMA_A_LVL_STAT: begin
        dec_acc = cma_pkg::CMA_ACC_MRO;
        dec_src = cma_pkg::CMA_SRC_CONST;
        dec_hit = clic_on;
      end
      default: dec_hit = 1'b0;
    endcase
  end

  // Access checks.
  wire is_m    = (priv_lvl == `CMA_PRIV_M);
  wire priv_ok = (dec_acc == cma_pkg::CMA_ACC_DRW) ? debug_mode
                                                  : (is_m | debug_mode);
  wire ro_hit  = (dec_acc == cma_pkg::CMA_ACC_MRO) & csr_wr;
  // Field legality is never checked, so WLRL writes pass.
  wire legal   = dec_hit & priv_ok & ~ro_hit;
  wire do_wr   = csr_req & csr_wr & legal;
  wire hi_half = csr_addr[7];

  wire wr_reg  = do_wr & (dec_src == cma_pkg::CMA_SRC_REG);
  wire wr_cyc  = do_wr & (dec_src == cma_pkg::CMA_SRC_CYC);
  wire wr_ret  = do_wr & (dec_src == cma_pkg::CMA_SRC_RET);

  wire [31:0] inhibit = regs_q[6];
  wire [31:0] rd_reg  = regs_q[dec_idx];
  wire [31:0] rd_cyc  = hi_half ? cyc_q[63:32] : cyc_q[31:0];
  wire [31:0] rd_ret  = hi_half ? ret_q[63:32] : ret_q[31:0];
  wire [31:0] rd_val  = (dec_src == cma_pkg::CMA_SRC_CYC) ? rd_cyc :
                        (dec_src == cma_pkg::CMA_SRC_RET) ? rd_ret :
                        (dec_src == cma_pkg::CMA_SRC_CONST) ? dec_const : rd_reg;

  // A software write to a counter half wins over the count in that cycle.
  wire [63:0] cyc_inc = cyc_q + {63'h0, ~inhibit[`CMA_INH_CYCLE]};
  wire [63:0] ret_inc = ret_q + {63'h0, instr_retire & ~inhibit[`CMA_INH_RETIRE]};
  wire [63:0] cyc_d   = ~wr_cyc ? cyc_inc :
                        hi_half ? {csr_wdata, cyc_inc[31:0]} : {cyc_inc[63:32], csr_wdata};
  wire [63:0] ret_d   = ~wr_ret ? ret_inc :
                        hi_half ? {csr_wdata, ret_inc[31:0]} : {ret_inc[63:32], csr_wdata};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_q <= 64'h0000_0000_0000_0000;
      ret_q <= 64'h0000_0000_0000_0000;
    end else begin
      cyc_q <= cyc_d;
      ret_q <= ret_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NR; i++) begin
        regs_q[i] <= `CMA_RST_VAL;
      end
    end else if (wr_reg) begin
      regs_q[dec_idx] <= csr_wdata;
    end
  end

  // Read data shows the value before the write of the same instruction.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csr_done_q    <= 1'b0;
      csr_illegal_q <= 1'b0;
      csr_rdata_q   <= `CMA_RST_VAL;
    end else begin
      csr_done_q    <= csr_req;
      csr_illegal_q <= csr_req & ~legal;
      csr_rdata_q   <= (csr_req & legal) ? rd_val : `CMA_RST_VAL;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  unimpl_addr_illegal_a: assert property (
    csr_req && csr_addr == 12'h7FF |=> csr_done_q && csr_illegal_q)
    else $error("unimplemented address not refused");
  clic_gate_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_NXT_IRQ |=> csr_illegal_q == !clic_on)
    else $error("interrupt-controller gate wrong");
  trig_gate_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_TCTRL |=> csr_illegal_q == !trig_on)
    else $error("trigger gate wrong");
  param_gate_a: assert property (
    csr_req && debug_mode && csr_addr == `CMA_A_TVT |=> csr_illegal_q == !clic_on)
    else $error("parameter gate wrong");
  ro_write_a: assert property (
    csr_req && csr_wr && csr_addr == `CMA_A_HART |=> csr_illegal_q)
    else $error("read-only write not refused");
  low_priv_a: assert property (
    csr_req && !is_m && !debug_mode |=> csr_illegal_q && csr_rdata_q == 32'h0000_0000)
    else $error("low privilege access not refused");
  debug_only_a: assert property (
    csr_req && (csr_addr == `CMA_A_DBG_CS) |=> csr_illegal_q == !$past(debug_mode))
    else $error("debug register gate wrong");
  always_on_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_MSCRATCH |=> !csr_illegal_q)
    else $error("unconditional register refused");
  wlrl_ok_a: assert property (
    csr_req && csr_wr && is_m && csr_addr == `CMA_A_CAUSE |=> !csr_illegal_q)
    else $error("field value write refused");
  rw_return_a: assert property (
    csr_req && csr_wr && is_m && csr_addr == `CMA_A_MSCRATCH
    ##1 csr_req && !csr_wr && is_m && csr_addr == `CMA_A_MSCRATCH
    |=> csr_rdata_q == $past(csr_wdata, 2))
    else $error("written value not returned");
  cyc_high_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_CYC_HI |=> csr_rdata_q == $past(cyc_q[63:32]))
    else $error("cycle upper half wrong");
  full_decode_a: assert property (
    csr_req && is_m && csr_addr == 12'hF40 |=> csr_illegal_q)
    else $error("partial address decode");

  // Answer framing: every request gets exactly one answer and idle cycles stay quiet.
  done_pulse_a: assert property (
    csr_req
    |=> csr_done_q)
    else $error("request not answered");

  quiet_idle_a: assert property (
    !csr_req
    |=> !csr_done_q && !csr_illegal_q && csr_rdata_q == `CMA_RST_VAL)
    else $error("answer without request");

  illegal_zero_a: assert property (
    csr_illegal_q
    |-> csr_rdata_q == `CMA_RST_VAL)
    else $error("refused access leaks data");

  illegal_done_a: assert property (
    csr_illegal_q
    |-> csr_done_q)
    else $error("refusal outside an answer");

  hart_const_a: assert property (
    csr_req && !csr_wr && is_m && csr_addr == `CMA_A_HART
    |=> !csr_illegal_q && csr_rdata_q == hart_id)
    else $error("hart index read wrong");

  dbg_scratch_a: assert property (
    csr_req && csr_addr == `CMA_A_DSCR1
    |=> csr_illegal_q == !$past(debug_mode))
    else $error("debug scratch gate wrong");

  trig_sel_gate_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_TSEL
    |=> csr_illegal_q == !trig_on)
    else $error("trigger select gate wrong");

  swap_lvl_gate_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_SWAP_LVL
    |=> csr_illegal_q == !clic_on)
    else $error("level swap gate wrong");

  lvl_stat_gate_a: assert property (
    csr_req && !csr_wr && is_m && csr_addr == `CMA_A_LVL_STAT
    |=> csr_illegal_q == !clic_on)
    else $error("level status gate wrong");

  // Counter behaviour; the checks read the 64-bit state directly.
  cyc_low_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_CYC_LO
    |=> csr_rdata_q == $past(cyc_q[31:0]))
    else $error("cycle lower half wrong");

  cyc_count_a: assert property (
    !wr_cyc && !inhibit[`CMA_INH_CYCLE]
    |=> cyc_q == $past(cyc_q) + 64'h1)
    else $error("cycle count did not advance");

  cyc_write_a: assert property (
    wr_cyc && !hi_half
    |=> cyc_q[31:0] == $past(csr_wdata))
    else $error("cycle lower half write lost");

  ret_high_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_RET_HI
    |=> csr_rdata_q == $past(ret_q[63:32]))
    else $error("retired upper half wrong");

  retire_count_a: assert property (
    instr_retire && !inhibit[`CMA_INH_RETIRE] && !wr_ret
    |=> ret_q == $past(ret_q) + 64'h1)
    else $error("retired count did not advance");

  ret_hold_a: assert property (
    !instr_retire && !wr_ret
    |=> $stable(ret_q))
    else $error("retired count moved");

  debug_grant_a: assert property (
    csr_req && debug_mode && csr_addr == `CMA_A_MSCRATCH
    |=> !csr_illegal_q)
    else $error("debug mode refused machine register");

  isa_always_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_ISA
    |=> !csr_illegal_q)
    else $error("extension register refused");

  tvec_always_a: assert property (
    csr_req && is_m && csr_addr == `CMA_A_TVEC
    |=> !csr_illegal_q)
    else $error("trap base register refused");

  perf_gap_a: assert property (
    csr_req && csr_addr == 12'h324
    |=> csr_illegal_q)
    else $error("missing event selector accepted");

  low_alias_a: assert property (
    csr_req && csr_addr == 12'h140
    |=> csr_illegal_q)
    else $error("upper address bits ignored");

  high_alias_a: assert property (
    csr_req && csr_addr == 12'hB40
    |=> csr_illegal_q)
    else $error("counter address alias accepted");

  // Storage: a refused write must leave every register as it was.
  write_store_a: assert property (
    wr_reg
    |=> regs_q[$past(dec_idx)] == $past(csr_wdata))
    else $error("register write lost");

  illegal_keep_a: assert property (
    csr_req && csr_wr && !legal && dec_src == cma_pkg::CMA_SRC_REG
    |=> regs_q[$past(dec_idx)] == $past(rd_reg))
    else $error("refused write changed storage");

  reg_hold_a: assert property (
    !wr_reg
    |=> $stable(regs_q[9]))
    else $error("scratch changed without write");

  cover_rw_c: cover property (csr_req && csr_wr && legal ##1 csr_done_q);
  cover_ro_c: cover property (csr_req && ro_hit ##1 csr_illegal_q);
  cover_dbg_c: cover property (csr_req && debug_mode && dec_acc == cma_pkg::CMA_ACC_DRW);
  cover_cnt_c: cover property (wr_cyc ##1 csr_done_q);
  cover_priv_c: cover property (csr_req && !is_m && !debug_mode ##1 csr_illegal_q);

endmodule
`default_nettype wire

// ==== include/cma_csr_cfg.svh ====
`ifndef CMA_CSR_CFG_SVH
`define CMA_CSR_CFG_SVH
`define CMA_PRIV_M         2'h3
`define CMA_RST_VAL        32'h0000_0000
`define CMA_INH_CYCLE      0
`define CMA_INH_RETIRE     2
`define CMA_A_STATUS       12'h300
`define CMA_A_ISA          12'h301
`define CMA_A_IE           12'h304
`define CMA_A_TVEC         12'h305
`define CMA_A_TVT          12'h307
`define CMA_A_STATUSH      12'h310
`define CMA_A_CNTINH       12'h320
`define CMA_A_HPMEV3       12'h323
`define CMA_A_HPMEV31      12'h33F
`define CMA_A_MSCRATCH     12'h340
`define CMA_A_TRAP_PC      12'h341
`define CMA_A_CAUSE        12'h342
`define CMA_A_TVAL         12'h343
`define CMA_A_IRQ_PEND     12'h344
`define CMA_A_NXT_IRQ      12'h345
`define CMA_A_THRESH       12'h347
`define CMA_A_SWAP_PRIV    12'h348
`define CMA_A_SWAP_LVL     12'h349
`define CMA_A_TSEL         12'h7A0
`define CMA_A_TRIGGER_DATA_1       12'h7A1
`define CMA_A_TRIGGER_DATA_2       12'h7A2
`define CMA_A_TRIGGER_DATA_3       12'h7A3
`define CMA_A_TINFO        12'h7A4
`define CMA_A_TCTRL        12'h7A5
`define CMA_A_DBG_CS       12'h7B0
`define CMA_A_DBG_PC       12'h7B0
`define CMA_A_DSCR0        12'h7B1
`define CMA_A_DSCR1        12'h7B2
`define CMA_A_CYC_LO       12'hB00
`define CMA_A_RET_LO       12'hB02
`define CMA_A_HPMC3        12'hB03
`define CMA_A_HPMC31       12'hB1F
`define CMA_A_CYC_HI       12'hB80
`define CMA_A_RET_HI       12'hB82
`define CMA_A_HPMCH3       12'hB83
`define CMA_A_HPMCH31      12'hB9F
`define CMA_A_VENDOR       12'hF11
`define CMA_A_ARCH         12'hF12
`define CMA_A_IMPL         12'hF13
`define CMA_A_HART         12'hF14
`define CMA_A_CFGPTR       12'hF15
`define CMA_A_LVL_STAT     12'hF46
`define CMA_NREG           33
`endif

// ==== include/cma_pkg.sv ====
package cma_pkg;
  typedef enum logic [2:0] {
    CMA_ACC_NONE = 3'h0,
    CMA_ACC_MRW  = 3'h1,
    CMA_ACC_MRO  = 3'h2,
    CMA_ACC_DRW  = 3'h3
  } cma_acc_t;
  typedef enum logic [1:0] {
    CMA_SRC_REG  = 2'h0,
    CMA_SRC_CYC  = 2'h1,
    CMA_SRC_RET  = 2'h2,
    CMA_SRC_CONST = 2'h3
  } cma_src_t;
endpackage

// ==== testbench/cma_csr_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys      = 1'b0;
  logic        rst          = 1'b1;
  logic        csr_req      = 1'b0;
  logic [11:0] csr_addr     = 12'h000;
  logic        csr_wr       = 1'b0;
  logic [31:0] csr_wdata    = 32'h0;
  logic [1:0]  priv_lvl     = 2'h3;
  logic        debug_mode   = 1'b0;
  logic        instr_retire = 1'b0;
  logic        skip_rd      = 1'b0;
  logic        done_a;
  logic        done_b;
  logic        ill_a;
  logic        ill_b;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic [81:0] rows [$];
  logic [11:0] fixed_a [12] = '{12'h301, 12'h304, 12'h305, 12'h310, 12'h323, 12'h33F,
                                12'h341, 12'h342, 12'h343, 12'h344, 12'hB03, 12'hB9F};
  int          num_errors   = 0;
  int          checked      = 0;
  int          cycles       = 0;

  // Two builds side by side, so each gated register the rows access is seen both present and absent.
  cma_csr_bank #(.clic_mode_param(1), .trigger_count_param(0)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .csr_req(csr_req), .csr_addr(csr_addr),
    .csr_wr(csr_wr), .csr_wdata(csr_wdata), .priv_lvl(priv_lvl), .debug_mode(debug_mode),
    .instr_retire(instr_retire), .csr_done_q(done_a), .csr_illegal_q(ill_a),
    .csr_rdata_q(rd_a));
  cma_csr_bank #(.clic_mode_param(0), .trigger_count_param(1)) dut_u2 (
    .clk_sys(clk_sys), .rst(rst), .csr_req(csr_req), .csr_addr(csr_addr),
    .csr_wr(csr_wr), .csr_wdata(csr_wdata), .priv_lvl(priv_lvl), .debug_mode(debug_mode),
    .instr_retire(instr_retire), .csr_done_q(done_b), .csr_illegal_q(ill_b),
    .csr_rdata_q(rd_b));

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // The request is dropped at the checking edge, so each access costs two cycles.
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] pm, input logic [1:0] il, input logic [31:0] r);
    @(negedge clk_sys);
    csr_req = 1'b1;
    csr_addr = a;
    csr_wr = w;
    csr_wdata = d;
    {debug_mode, priv_lvl} = pm;
    @(negedge clk_sys);
    csr_req = 1'b0;
    chk("done_a", 32'h1, {31'h0, done_a});
    chk("done_b", 32'h1, {31'h0, done_b});
    chk("illegal_a", {31'h0, il[1]}, {31'h0, ill_a});
    chk("illegal_b", {31'h0, il[0]}, {31'h0, ill_b});
    if (!skip_rd) begin
      chk("rdata_a", il[1] ? 32'h0 : r, rd_a);
      chk("rdata_b", il[0] ? 32'h0 : r, rd_b);
    end
  endtask

  task automatic row(input logic [81:0] v);
    rows.push_back(v);
  endtask

  initial begin
    row({12'h340, 1'h1, 32'hAAAA5555, 3'h3, 2'h0, 32'h0});
    row({12'h340, 1'h0, 32'h0, 3'h3, 2'h0, 32'hAAAA5555});
    row({12'h340, 1'h0, 32'h0, 3'h0, 2'h3, 32'h0});
    row({12'h340, 1'h1, 32'h1, 3'h1, 2'h3, 32'h0});
    row({12'h340, 1'h0, 32'h0, 3'h7, 2'h0, 32'hAAAA5555});
    row({12'h140, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'hB40, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'h324, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'h7B3, 1'h1, 32'h5, 3'h7, 2'h3, 32'h0});
    row({12'h345, 1'h1, 32'h12345678, 3'h3, 2'h1, 32'h0});
    row({12'h345, 1'h0, 32'h0, 3'h3, 2'h1, 32'h12345678});
    row({12'h349, 1'h0, 32'h0, 3'h3, 2'h1, 32'h0});
    row({12'h307, 1'h0, 32'h0, 3'h3, 2'h1, 32'h0});
    row({12'hF46, 1'h0, 32'h0, 3'h3, 2'h1, 32'h0});
    row({12'h307, 1'h0, 32'h0, 3'h7, 2'h1, 32'h0});
    row({12'h7A5, 1'h0, 32'h0, 3'h3, 2'h2, 32'h0});
    row({12'hF40, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'h7FF, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'hF14, 1'h1, 32'h9, 3'h3, 2'h3, 32'h0});
    row({12'h7A0, 1'h1, 32'h0000000F, 3'h3, 2'h2, 32'h0});
    row({12'h7A0, 1'h0, 32'h0, 3'h3, 2'h2, 32'h0000000F});
    row({12'h7B0, 1'h1, 32'hC0DE0001, 3'h3, 2'h3, 32'h0});
    row({12'h7B0, 1'h1, 32'hC0DE0001, 3'h7, 2'h0, 32'h0});
    row({12'h7B0, 1'h0, 32'h0, 3'h7, 2'h0, 32'hC0DE0001});
    row({12'h7B2, 1'h0, 32'h0, 3'h3, 2'h3, 32'h0});
    row({12'hF11, 1'h1, 32'h1, 3'h3, 2'h3, 32'h0});
    row({12'hF14, 1'h0, 32'h0, 3'h3, 2'h0, 32'h0});
    row({12'h300, 1'h1, 32'hFFFFFFFF, 3'h3, 2'h0, 32'h0});
    row({12'h300, 1'h0, 32'h0, 3'h3, 2'h0, 32'hFFFFFFFF});
    repeat (5) @(negedge clk_sys);
    chk("reset_done", 32'h0, {31'h0, done_a});
    chk("reset_rdata", 32'h0, rd_b);
    rst = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i][81:70], rows[i][69], rows[i][68:37], rows[i][36:34], rows[i][33:32],
          rows[i][31:0]);
    end
    foreach (fixed_a[i]) begin
      acc(fixed_a[i], 1'h1, {20'h0, fixed_a[i]}, 3'h3, 2'h0, 32'h0);
      acc(fixed_a[i], 1'h0, 32'h0, 3'h3, 2'h0, {20'h0, fixed_a[i]});
    end
    // The low half is seeded close to wrap so the carry into the upper half shows.
    acc(12'hB80, 1'h1, 32'h7, 3'h3, 2'h0, 32'h0);
    skip_rd = 1'b1;
    acc(12'hB00, 1'h1, 32'hFFFFFFFD, 3'h3, 2'h0, 32'h0);
    skip_rd = 1'b0;
    acc(12'hB00, 1'h0, 32'h0, 3'h3, 2'h0, 32'hFFFFFFFE);
    acc(12'hB80, 1'h0, 32'h0, 3'h3, 2'h0, 32'h8);
    skip_rd = 1'b1;
    acc(12'hB02, 1'h1, 32'hA, 3'h3, 2'h0, 32'h0);
    skip_rd = 1'b0;
    @(negedge clk_sys);
    instr_retire = 1'b1;
    repeat (3) @(negedge clk_sys);
    instr_retire = 1'b0;
    acc(12'hB02, 1'h0, 32'h0, 3'h3, 2'h0, 32'hD);
    acc(12'hB82, 1'h0, 32'h0, 3'h3, 2'h0, 32'h0);
    // Back-to-back write then read of the same register, with no idle cycle between.
    @(negedge clk_sys);
    {csr_req, csr_wr, csr_addr, csr_wdata} = {1'b1, 1'b1, 12'h340, 32'h5A5A0F0F};
    @(negedge clk_sys);
    csr_wr = 1'b0;
    @(negedge clk_sys);
    csr_req = 1'b0;
    chk("b2b_a", 32'h5A5A0F0F, rd_a);
    chk("b2b_b", 32'h5A5A0F0F, rd_b);
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    acc(12'h340, 1'h0, 32'h0, 3'h3, 2'h0, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
